// >>> uart_tx_rx_datapath.sv
// Summary of operation
// - buffer-empty flag mirrors an empty transmit buffer
// - buffer-empty request holds while flag and enable
// - data register write clears buffer-empty flag
// - complete flag sets when frame out, buffer empty
// - complete flag clears on service or one-write
// - complete request raised when flag sets, enabled
// - parity bit after data, before stop bits
// - disable waits for shifter and buffer empty
// - disabled transmitter releases the output pin
// - receiver enable routes input pin to receiver
// - sync mode uses external sync clock
// - valid start bit, then sample and shift
// - second stop bit ignored by receiver
// - first stop bit moves frame into buffer
// - unused high data bits read as zero
// - ninth bit and errors stored per fifo entry
// - shifter loads when idle or after stop
// - low start bit, then data lsb first
// - receiver disable flushes buffer, clears flag
`include "uart_tx_rx_datapath_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module uart_tx_rx_datapath
    import uart_pkg::*;
#(
    parameter int unsigned BAUD_DIV = `BAUD_DIV_DEFAULT,
    parameter int unsigned FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic rxdPin,
    input wire logic syncClockPin,
    output logic txdOut,
    output logic txdOe,
    output logic rxOwnsPin,
    output logic bufEmptyIrq,
    output logic txCompleteIrq,
    input wire logic txCompleteAck
);
    localparam int unsigned PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

    // refuse settings the counters and fifo pointers cannot serve
    if (BAUD_DIV < 4 || BAUD_DIV > 65535) begin : g_bad_div
        $error("BAUD_DIV out of range");
    end
    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO_DEPTH must be a power of two, at least 2");
    end

    // bits of data for a size code; codes 4..6 alias codes 0..2 (five to seven)
    function automatic logic [3:0] dataBits(input logic [2:0] code);
        if (code == `SIZE_NINE) return `NINE_BITS;
        return `FIVE_BITS + {2'h0, code[1:0]};
    endfunction : dataBits

    // parity over the low n bits, inverted for odd
    function automatic logic parityOf(input logic [8:0] d, input logic [3:0] n, input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < n) p = p ^ d[i];
        end
        return p;
    endfunction : parityOf

    // zero the bits at and above n
    function automatic logic [8:0] maskData(input logic [8:0] d, input logic [3:0] n);
        logic [8:0] m;
        m = d;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) >= n) m[i] = 1'b0;
        end
        return m;
    endfunction : maskData

    logic rxdMeta_ff, rxdSync_ff, xckMeta_ff, xckSync_ff, xckPrev_ff;
    logic [15:0] baudCnt_ff, nxt_baudCnt;
    logic tx_buffer_empty_irq_enable_ff, tx_complete_irq_enable_ff, receiver_enable_ff, transmitter_enable_ff, tx9_ff, stop2_ff, syncMode_ff;
    logic nxt_tx_buffer_empty_irq_enable, nxt_tx_complete_irq_enable, nxt_receiver_enable, nxt_transmitter_enable, nxt_tx9, nxt_stop2, nxt_syncMode;
    logic [2:0] sizeCode_ff, nxt_sizeCode;
    logic [1:0] parMode_ff, nxt_parMode;
    logic [8:0] txBuf_ff, nxt_txBuf;
    logic txBufFull_ff, nxt_txBufFull, txBusy_ff, nxt_txBusy, txc_ff, nxt_txc;
    logic [12:0] txShift_ff, nxt_txShift;
    logic [3:0] txLeft_ff, nxt_txLeft;
    logic txd_ff, nxt_txd, txOe_ff, nxt_txOe, udreIrq_ff, nxt_udreIrq, txcIrq_ff, nxt_txcIrq;
    rx_state_t rxState_ff, nxt_rxState;
    logic [15:0] rxDiv_ff, nxt_rxDiv;
    logic [3:0] rxIdx_ff, nxt_rxIdx;
    logic [10:0] rxShift_ff, nxt_rxShift;
    fifo_entry_t fifoMem_ff [FIFO_DEPTH];
    logic [PTR_W-1:0] wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
    logic [PTR_W:0] count_ff, nxt_count;
    logic dorPend_ff, nxt_dorPend;
    logic [7:0] rdData_ff, nxt_rdData;
    logic pushEn;
    fifo_entry_t pushEntry, head;
    logic xckRise, xckFall, txTick, sampleNow, rxBit;
    logic [3:0] nBits, txLen, rxLast;
    logic [8:0] rxData;

    assign regRdData = rdData_ff;
    assign txdOut = txd_ff;
    assign txdOe = txOe_ff;
    assign rxOwnsPin = receiver_enable_ff;
    assign bufEmptyIrq = udreIrq_ff;
    assign txCompleteIrq = txcIrq_ff;

    // pin sampling; edges only look at the second stage and beyond
    always_ff @(posedge clock) begin
        rxdMeta_ff <= rxdPin;
        rxdSync_ff <= rxdMeta_ff;
        xckMeta_ff <= syncClockPin;
        xckSync_ff <= xckMeta_ff;
        xckPrev_ff <= xckSync_ff;
    end

    assign xckRise = xckSync_ff & ~xckPrev_ff;
    assign xckFall = ~xckSync_ff & xckPrev_ff;
    assign head = fifoMem_ff[rdPtr_ff];
    assign nBits = dataBits(sizeCode_ff);
    // idle level reaches the receiver while it does not own the pin
    assign rxBit = rxdSync_ff | ~receiver_enable_ff;
    // bit clock: divider in async mode, external edges in sync mode
    assign txTick = syncMode_ff ? xckFall : (baudCnt_ff == 16'h0000);
    assign sampleNow = syncMode_ff ? xckRise : (rxDiv_ff == 16'h0000);
    assign txLen = 4'h2 + nBits + {3'h0, parMode_ff[1]} + {3'h0, stop2_ff};
    // index of the first stop bit; a second one is never sampled
    assign rxLast = nBits + {3'h0, parMode_ff[1]};
    assign rxData = maskData(rxShift_ff[8:0], nBits);

    // next-state logic for registers, transmitter and receiver
    always_comb begin
        logic [12:0] frame;
        logic [8:0] d9;
        frame = '1;
        d9 = txBuf_ff;
        nxt_tx_buffer_empty_irq_enable = tx_buffer_empty_irq_enable_ff;
        nxt_tx_complete_irq_enable = tx_complete_irq_enable_ff;
        nxt_receiver_enable = receiver_enable_ff;
        nxt_transmitter_enable = transmitter_enable_ff;
        nxt_tx9 = tx9_ff;
        nxt_stop2 = stop2_ff;
        nxt_syncMode = syncMode_ff;
        nxt_sizeCode = sizeCode_ff;
        nxt_parMode = parMode_ff;
        nxt_txBuf = txBuf_ff;
        nxt_txBufFull = txBufFull_ff;
        nxt_txBusy = txBusy_ff;
        nxt_txc = txc_ff;
        nxt_txShift = txShift_ff;
        nxt_txLeft = txLeft_ff;
        nxt_txd = txd_ff;
        nxt_baudCnt = (baudCnt_ff == 16'h0000) ? 16'(BAUD_DIV - 1) : baudCnt_ff - 16'h0001;
        nxt_rxState = rxState_ff;
        nxt_rxDiv = (rxDiv_ff == 16'h0000) ? 16'(BAUD_DIV - 1) : rxDiv_ff - 16'h0001;
        nxt_rxIdx = rxIdx_ff;
        nxt_rxShift = rxShift_ff;
        nxt_wrPtr = wrPtr_ff;
        nxt_rdPtr = rdPtr_ff;
        nxt_count = count_ff;
        nxt_dorPend = dorPend_ff;
        nxt_rdData = 8'h00;
        pushEn = 1'b0;
        pushEntry = '0;

        // frame image: start low, data lsb first, parity, stop ones
        frame[0] = 1'b0;
        for (int i = 0; i < 9; i++) begin
            if (4'(i) < nBits) frame[i + 1] = d9[i];
        end
        if (parMode_ff[1]) frame[nBits + 4'h1] = parityOf(d9, nBits, parMode_ff[0]);

        // shifter: reload straight after the last stop bit or from idle
        if (txTick && txBusy_ff && txLeft_ff != 4'h0) begin
            nxt_txd = txShift_ff[0];
            nxt_txShift = {1'b1, txShift_ff[12:1]};
            nxt_txLeft = txLeft_ff - 4'h1;
        end else if (txTick && txBufFull_ff && txOe_ff) begin
            nxt_txd = frame[0];
            nxt_txShift = {1'b1, frame[12:1]};
            nxt_txLeft = txLen - 4'h1;
            nxt_txBusy = 1'b1;
            nxt_txBufFull = 1'b0;
        end else if (txTick && txBusy_ff) begin
            nxt_txBusy = 1'b0;
            nxt_txd = 1'b1;
        end
        // override lasts while enabled or data is still pending
        nxt_txOe = transmitter_enable_ff | nxt_txBusy | (txOe_ff & nxt_txBufFull);
        if (!nxt_txOe) nxt_txd = 1'b1;

        // receiver
        if (!receiver_enable_ff) begin
            nxt_rxState = RX_IDLE;
        end else begin
            unique case (rxState_ff)
                RX_IDLE: begin
                    if (!rxBit && !syncMode_ff) begin
                        nxt_rxState = RX_START;
                        nxt_rxDiv = 16'(BAUD_DIV / 2);
                    end else if (!rxBit && xckRise) begin
                        nxt_rxState = RX_BITS;
                        nxt_rxIdx = 4'h0;
                    end
                end
                RX_START: begin
                    // a glitch shorter than half a bit is not a start
                    if (sampleNow) begin
                        nxt_rxState = rxBit ? RX_IDLE : RX_BITS;
                        nxt_rxIdx = 4'h0;
                    end
                end
                RX_BITS: begin
                    if (sampleNow) begin
                        nxt_rxShift[rxIdx_ff] = rxBit;
                        nxt_rxIdx = rxIdx_ff + 4'h1;
                        if (rxIdx_ff == rxLast) begin
                            nxt_rxState = RX_IDLE;
                            pushEntry[7:0] = rxData[7:0];
                            pushEntry[`EN_RX9] = rxData[8];
                            pushEntry[`EN_FRAME] = ~rxBit;
                            pushEntry[`EN_OVER] = dorPend_ff;
                            pushEntry[`EN_PAR] = parMode_ff[1]
                                & (parityOf(rxShift_ff[8:0], nBits, parMode_ff[0])
                                ^ rxShift_ff[nBits]);
                            // full buffer loses the frame and flags the next one
                            if (count_ff != (PTR_W + 1)'(FIFO_DEPTH)) begin
                                pushEn = 1'b1;
                                nxt_dorPend = 1'b0;
                            end else begin
                                nxt_dorPend = 1'b1;
                            end
                        end
                    end
                end
                default: nxt_rxState = RX_IDLE;
            endcase
        end

        // register writes
        if (regWr) begin
            unique case (regAddr)
                `ADDR_DATA: begin
                    nxt_txBuf = {tx9_ff, regWrData};
                    nxt_txBufFull = 1'b1;
                end
                `ADDR_STATUS: if (regWrData[`ST_TX_DONE]) nxt_txc = 1'b0;
                `ADDR_CONTROL: begin
                    nxt_tx_complete_irq_enable = regWrData[`CT_DONE_IRQ];
                    nxt_tx_buffer_empty_irq_enable = regWrData[`CT_EMPTY_IRQ];
                    nxt_receiver_enable = regWrData[`CT_RX_ON];
                    nxt_transmitter_enable = regWrData[`CT_TX_ON];
                    nxt_tx9 = regWrData[`CT_TX9];
                end
                `ADDR_CONFIG: begin
                    nxt_sizeCode = regWrData[`CF_SIZE_LO +: 3];
                    nxt_parMode = regWrData[`CF_PAR_LO +: 2];
                    nxt_stop2 = regWrData[`CF_STOP2];
                    nxt_syncMode = regWrData[`CF_SYNC];
                end
                default: ;
            endcase
        end
        if (txCompleteAck) nxt_txc = 1'b0;
        // set wins over a clear in the same cycle
        if (txTick && txBusy_ff && txLeft_ff == 4'h0 && !(txBufFull_ff && txOe_ff))
            nxt_txc = 1'b1;

        // register reads; a data read advances the fifo
        if (regRd) begin
            unique case (regAddr)
                `ADDR_DATA: begin
                    nxt_rdData = head[7:0];
                    if (count_ff != '0) begin
                        nxt_rdPtr = rdPtr_ff + 1'b1;
                        nxt_count = count_ff - 1'b1;
                    end
                end
                `ADDR_STATUS: begin
                    nxt_rdData[`ST_RX_DONE] = (count_ff != '0);
                    nxt_rdData[`ST_TX_DONE] = txc_ff;
                    nxt_rdData[`ST_EMPTY] = ~txBufFull_ff;
                    nxt_rdData[`ST_FRAME] = head[`EN_FRAME] & (count_ff != '0);
                    nxt_rdData[`ST_OVER] = head[`EN_OVER] & (count_ff != '0);
                    nxt_rdData[`ST_PAR] = head[`EN_PAR] & (count_ff != '0);
                end
                `ADDR_CONTROL: begin
                    nxt_rdData[`CT_DONE_IRQ] = tx_complete_irq_enable_ff;
                    nxt_rdData[`CT_EMPTY_IRQ] = tx_buffer_empty_irq_enable_ff;
                    nxt_rdData[`CT_RX_ON] = receiver_enable_ff;
                    nxt_rdData[`CT_TX_ON] = transmitter_enable_ff;
                    nxt_rdData[`CT_RX9] = head[`EN_RX9] & (count_ff != '0);
                    nxt_rdData[`CT_TX9] = tx9_ff;
                end
                `ADDR_CONFIG: begin
                    nxt_rdData[`CF_SIZE_LO +: 3] = sizeCode_ff;
                    nxt_rdData[`CF_PAR_LO +: 2] = parMode_ff;
                    nxt_rdData[`CF_STOP2] = stop2_ff;
                    nxt_rdData[`CF_SYNC] = syncMode_ff;
                end
                default: nxt_rdData = 8'h00;
            endcase
        end
        if (pushEn) begin
            nxt_wrPtr = wrPtr_ff + 1'b1;
            nxt_count = nxt_count + 1'b1;
        end
        if (!receiver_enable_ff) begin
            nxt_rdPtr = wrPtr_ff;
            nxt_count = '0;
            nxt_dorPend = 1'b0;
        end
        // requests track the enables and flags of the same cycle
        nxt_udreIrq = nxt_tx_buffer_empty_irq_enable & ~nxt_txBufFull;
        nxt_txcIrq = nxt_tx_complete_irq_enable & nxt_txc;
    end

    // fifo storage, written by index
    always_ff @(posedge clock) begin
        if (pushEn) fifoMem_ff[wrPtr_ff] <= pushEntry;
    end

    // state registers
    always_ff @(posedge clock) begin
        if (rst) begin
            baudCnt_ff <= 16'h0000;
            {tx_buffer_empty_irq_enable_ff, tx_complete_irq_enable_ff, receiver_enable_ff, transmitter_enable_ff, tx9_ff} <= 5'h00;
            {stop2_ff, syncMode_ff, parMode_ff} <= 4'h0;
            sizeCode_ff <= `SIZE_RESET;
            txBuf_ff <= 9'h000;
            {txBufFull_ff, txBusy_ff, txc_ff, txOe_ff} <= 4'h0;
            txShift_ff <= 13'h1FFF;
            txLeft_ff <= 4'h0;
            txd_ff <= 1'b1;
            {udreIrq_ff, txcIrq_ff, dorPend_ff} <= 3'h0;
            rxState_ff <= RX_IDLE;
            rxDiv_ff <= 16'h0000;
            rxIdx_ff <= 4'h0;
            rxShift_ff <= 11'h000;
            wrPtr_ff <= '0;
            rdPtr_ff <= '0;
            count_ff <= '0;
            rdData_ff <= 8'h00;
        end else begin
            baudCnt_ff <= nxt_baudCnt;
            {tx_buffer_empty_irq_enable_ff, tx_complete_irq_enable_ff, receiver_enable_ff, transmitter_enable_ff, tx9_ff} <=
                {nxt_tx_buffer_empty_irq_enable, nxt_tx_complete_irq_enable, nxt_receiver_enable, nxt_transmitter_enable, nxt_tx9};
            {stop2_ff, syncMode_ff, parMode_ff} <= {nxt_stop2, nxt_syncMode, nxt_parMode};
            sizeCode_ff <= nxt_sizeCode;
            txBuf_ff <= nxt_txBuf;
            {txBufFull_ff, txBusy_ff, txc_ff, txOe_ff} <=
                {nxt_txBufFull, nxt_txBusy, nxt_txc, nxt_txOe};
            txShift_ff <= nxt_txShift;
            txLeft_ff <= nxt_txLeft;
            txd_ff <= nxt_txd;
            {udreIrq_ff, txcIrq_ff, dorPend_ff} <= {nxt_udreIrq, nxt_txcIrq, nxt_dorPend};
            rxState_ff <= nxt_rxState;
            rxDiv_ff <= nxt_rxDiv;
            rxIdx_ff <= nxt_rxIdx;
            rxShift_ff <= nxt_rxShift;
            wrPtr_ff <= nxt_wrPtr;
            rdPtr_ff <= nxt_rdPtr;
            count_ff <= nxt_count;
            rdData_ff <= nxt_rdData;
        end
    end

    property p_tx_buffer_empty_flag_irq;
        @(posedge clock) disable iff (rst) (tx_buffer_empty_irq_enable_ff && !txBufFull_ff) |-> bufEmptyIrq;
    endproperty
    a_tx_buffer_empty_flag_irq: assert property (p_tx_buffer_empty_flag_irq) else $error("empty request missing");
    property p_write_clears;
        @(posedge clock) disable iff (rst) (regWr && regAddr == `ADDR_DATA) |=> txBufFull_ff;
    endproperty
    a_write_clears: assert property (p_write_clears) else $error("buffer not full");
    property p_full_holds;
        @(posedge clock) disable iff (rst) (txBufFull_ff && !txTick) |=> txBufFull_ff;
    endproperty
    a_full_holds: assert property (p_full_holds) else $error("buffer lost data");
    property p_txc_set;
        @(posedge clock) disable iff (rst) $rose(txc_ff) |-> !txBufFull_ff && !txBusy_ff;
    endproperty
    a_txc_set: assert property (p_txc_set) else $error("complete too early");
    property p_txc_ack;
        @(posedge clock) disable iff (rst)
            (txCompleteAck && !(txTick && txBusy_ff)) |=> !txc_ff;
    endproperty
    a_txc_ack: assert property (p_txc_ack) else $error("complete not cleared");
    property p_txc_irq;
        @(posedge clock) disable iff (rst) ($rose(txc_ff) && tx_complete_irq_enable_ff) |-> txCompleteIrq;
    endproperty
    a_txc_irq: assert property (p_txc_irq) else $error("complete request missing");
    property p_disable_waits;
        @(posedge clock) disable iff (rst) (txOe_ff && (txBufFull_ff
            || (txBusy_ff && (!txTick || txLeft_ff != 4'h0)))) |=> txdOe;
    endproperty
    a_disable_waits: assert property (p_disable_waits) else $error("released early");
    property p_idle_high;
        @(posedge clock) disable iff (rst) !txBusy_ff |-> txdOut;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("idle line low");
    property p_flush;
        @(posedge clock) disable iff (rst) !receiver_enable_ff |=> count_ff == '0;
    endproperty
    a_flush: assert property (p_flush) else $error("fifo not flushed");
endmodule : uart_tx_rx_datapath
`default_nettype wire

// >>> uart_tx_rx_datapath_consts.svh
`ifndef UART_TX_RX_DATAPATH_CONSTS_SVH
`define UART_TX_RX_DATAPATH_CONSTS_SVH
// register offsets
`define ADDR_DATA 3'h0
`define ADDR_STATUS 3'h1
`define ADDR_CONTROL 3'h2
`define ADDR_CONFIG 3'h3
// status register bit positions
`define ST_RX_DONE 7
`define ST_TX_DONE 6
`define ST_EMPTY 5
`define ST_FRAME 4
`define ST_OVER 3
`define ST_PAR 2
// control register bit positions
`define CT_DONE_IRQ 6
`define CT_EMPTY_IRQ 5
`define CT_RX_ON 4
`define CT_TX_ON 3
`define CT_RX9 1
`define CT_TX9 0
// config register fields
`define CF_SIZE_LO 0
`define CF_PAR_LO 3
`define CF_STOP2 5
`define CF_SYNC 6
// receive fifo entry layout
`define EN_RX9 8
`define EN_FRAME 9
`define EN_OVER 10
`define EN_PAR 11
// encodings and reset values
`define SIZE_NINE 3'h7
`define SIZE_RESET 3'h3
`define NINE_BITS 4'h9
`define FIVE_BITS 4'h5
`define BAUD_DIV_DEFAULT 1085
`define FIFO_DEPTH_DEFAULT 2
`endif

// >>> uart_pkg.sv
package uart_pkg;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_BITS = 2'b10
    } rx_state_t;
    typedef logic [11:0] fifo_entry_t;
endpackage : uart_pkg

// >>> uart_remote_model.sv
`timescale 1ns/1ns
`default_nettype none
module uart_remote_model #(
    parameter int unsigned BAUD_DIV = 8
) (
    input wire logic clock,
    input wire logic txdOut,
    output logic rxdPin,
    output logic syncClockPin
);
    // line idles high; sync clock parked low between frames
    initial begin
        rxdPin = 1'b1;
        syncClockPin = 1'b0;
    end
    // mid-bit sampling, start search bounded so a dead line cannot hang us
    task automatic capture(input int nb, output logic [12:0] bits);
        int i;
        bits = '0;
        for (i = 0; i < 400 && txdOut !== 1'b0; i++) @(posedge clock);
        repeat (BAUD_DIV / 2) @(posedge clock);
        for (i = 0; i < nb; i++) begin
            if (i > 0) repeat (BAUD_DIV) @(posedge clock);
            bits[i] = txdOut;
        end
    endtask : capture
    // start low, data lsb first, optional parity, first stop may be bad
    task automatic send(input logic [8:0] d, input int n, input logic pe, input logic po,
            input logic s2, input logic stopOk, input logic sync);
        logic [12:0] b;
        logic p;
        int i;
        int nb;
        b = '0;
        p = po;
        for (i = 0; i < n; i++) begin
            b[i + 1] = d[i];
            p ^= d[i];
        end
        nb = n + 1;
        if (pe) begin
            b[nb] = p;
            nb++;
        end
        b[nb] = stopOk;
        b[nb + 1] = 1'b1;
        nb += 1 + int'(s2);
        for (i = 0; i < nb; i++) begin
            if (sync) begin
                // data moves on the falling edge, the far end samples on the rising one
                rxdPin <= b[i];
                #40 syncClockPin = 1'b1;
                #40 syncClockPin = 1'b0;
            end else begin
                @(posedge clock);
                rxdPin <= b[i];
                repeat (BAUD_DIV - 1) @(posedge clock);
            end
        end
        @(posedge clock);
        rxdPin <= 1'b1;
    endtask : send
endmodule : uart_remote_model
`default_nettype wire

// >>> uart_tx_rx_datapath_test.sv
`include "uart_tx_rx_datapath_consts.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_tx_rx_datapath_test;
    import uart_pkg::*;
    localparam int unsigned BAUD = 8; // short divider keeps the run small
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic txCompleteAck = 1'b0;
    logic [7:0] regRdData;
    logic rxdPin, syncClockPin, txdOut, txdOe, rxOwnsPin, bufEmptyIrq, txCompleteIrq;
    int n_mismatch = 0;
    int checks = 0;
    int unsigned seedVal;
    int nBits;
    logic [7:0] rv;
    logic [12:0] got0, got1;
    logic [8:0] d0, d1, msk;
    logic [2:0] code;
    logic pe, po, s2;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, `SIZE_NINE};
    always #4 clock = ~clock;
    uart_tx_rx_datapath #(.BAUD_DIV(BAUD), .FIFO_DEPTH(2)) dut (.clock(clock), .rst(rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .rxdPin(rxdPin), .syncClockPin(syncClockPin),
        .txdOut(txdOut), .txdOe(txdOe), .rxOwnsPin(rxOwnsPin), .bufEmptyIrq(bufEmptyIrq),
        .txCompleteIrq(txCompleteIrq), .txCompleteAck(txCompleteAck));
    uart_remote_model #(.BAUD_DIV(BAUD)) remote (.clock(clock), .txdOut(txdOut),
        .rxdPin(rxdPin), .syncClockPin(syncClockPin));
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask : rd
    task automatic waitStatus(input logic [7:0] m);
        int i;
        rv = 8'h00;
        for (i = 0; i < 400 && (rv & m) !== m; i++) rd(`ADDR_STATUS, rv);
    endtask : waitStatus
    // expected line bits, index 0 first on the wire
    function automatic logic [12:0] expFrame(input logic [8:0] d, input int n,
            input logic pe, input logic po, input logic s2);
        logic [12:0] f;
        logic p;
        int i;
        f = '0;
        p = po;
        for (i = 0; i < n; i++) begin
            f[i + 1] = d[i];
            p ^= d[i];
        end
        for (i = n + 1; i < n + 2 + int'(pe) + int'(s2); i++) f[i] = 1'b1;
        if (pe) f[n + 1] = p;
        return f;
    endfunction : expFrame
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop
    // watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clock);
        n_mismatch++;
        report_and_stop();
    end
    task automatic pickFormat(input int k);
        code = codes[k];
        nBits = (code == `SIZE_NINE) ? 9 : int'(code) + 5;
        msk = 9'((1 << nBits) - 1);
        pe = 1'($urandom);
        po = 1'($urandom);
        s2 = 1'($urandom);
        d0 = 9'($urandom);
        d1 = 9'($urandom);
        wr(`ADDR_CONFIG, {2'b00, s2, pe, po, code});
    endtask : pickFormat
    initial begin
        seedVal = $urandom(48945);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(`ADDR_STATUS, rv);
        `CHK(rv, 8'h20)
        rd(3'h5, rv);
        `CHK(rv, 8'h00)
        `CHK({txdOut, txdOe, rxOwnsPin}, 3'b100)
        $display("test reset done");
        // two frames back to back per format, second written while the first shifts
        for (int k = 0; k < 5; k++) begin
            pickFormat(k);
            fork
                begin
                    remote.capture(nBits + 2 + int'(pe) + int'(s2), got0);
                    remote.capture(nBits + 2 + int'(pe) + int'(s2), got1);
                end
                begin
                    wr(`ADDR_CONTROL, 8'h68 | {7'h00, d0[8]});
                    wr(`ADDR_DATA, d0[7:0]);
                    waitStatus(8'h20);
                    `CHK(bufEmptyIrq, 1'b1)
                    wr(`ADDR_CONTROL, 8'h68 | {7'h00, d1[8]});
                    wr(`ADDR_DATA, d1[7:0]);
                    rd(`ADDR_STATUS, rv);
                    `CHK(rv[6:5], 2'b00)
                    `CHK(bufEmptyIrq, 1'b0)
                end
            join
            `CHK(got0, expFrame(d0, nBits, pe, po, s2))
            `CHK(got1, expFrame(d1, nBits, pe, po, s2))
            waitStatus(8'h60);
            `CHK(txCompleteIrq, 1'b1)
            `CHK(txdOut, 1'b1)
            if (k % 2 == 1) begin
                wr(`ADDR_STATUS, 8'h40);
            end else begin
                @(posedge clock);
                txCompleteAck <= 1'b1;
                @(posedge clock);
                txCompleteAck <= 1'b0;
            end
            rd(`ADDR_STATUS, rv);
            `CHK(rv[6], 1'b0)
        end
        $display("test transmit done");
        // disable during a frame: pin kept until the frame is out
        wr(`ADDR_CONFIG, 8'h03);
        fork
            remote.capture(10, got0);
            begin
                wr(`ADDR_DATA, 8'hA5);
                wr(`ADDR_CONTROL, 8'h00);
                repeat (3 * BAUD) @(posedge clock);
                `CHK(txdOe, 1'b1)
            end
        join
        `CHK(got0, expFrame(9'h0A5, 8, 1'b0, 1'b0, 1'b0))
        repeat (2 * BAUD) @(posedge clock);
        `CHK(txdOe, 1'b0)
        $display("test disable done");
        wr(`ADDR_CONTROL, 8'h10);
        rd(`ADDR_CONTROL, rv);
        `CHK(rxOwnsPin, 1'b1)
        // good frame then bad first stop; wait lets any break echo drop on a full fifo
        for (int k = 0; k < 5; k++) begin
            pickFormat(k);
            remote.send(d0, nBits, pe, po, s2, 1'b1, 1'b0);
            remote.send(d1, nBits, pe, po, s2, 1'b0, 1'b0);
            repeat (16 * BAUD) @(posedge clock);
            rd(`ADDR_STATUS, rv);
            `CHK(rv & 8'h94, 8'h80)
            rd(`ADDR_CONTROL, rv);
            if (nBits == 9) `CHK(rv[1], d0[8])
            rd(`ADDR_DATA, rv);
            `CHK(rv, 8'(d0 & msk))
            rd(`ADDR_STATUS, rv);
            `CHK(rv & 8'h90, 8'h90)
            rd(`ADDR_CONTROL, rv);
            if (nBits == 9) `CHK(rv[1], d1[8])
            rd(`ADDR_DATA, rv);
            `CHK(rv, 8'(d1 & msk))
            rd(`ADDR_STATUS, rv);
            `CHK(rv[7], 1'b0)
        end
        $display("test receive done");
        wr(`ADDR_CONFIG, 8'h03);
        remote.send(9'h03C, 8, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        rd(`ADDR_STATUS, rv);
        `CHK(rv[7], 1'b1)
        wr(`ADDR_CONTROL, 8'h00);
        rd(`ADDR_STATUS, rv);
        `CHK({rv[7], rxOwnsPin}, 2'b00)
        // synchronous mode: bits clocked by the far end
        wr(`ADDR_CONFIG, 8'h43);
        wr(`ADDR_CONTROL, 8'h10);
        d0 = 9'($urandom);
        remote.send(d0, 8, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        repeat (4 * BAUD) @(posedge clock);
        rd(`ADDR_DATA, rv);
        `CHK(rv, d0[7:0])
        $display("test sync done");
        report_and_stop();
    end
endmodule : uart_tx_rx_datapath_test
`default_nettype wire
